// ==== lcc_cell.sv ====
// one logic cell: lookup table, adder, register next state and output selects
`timescale 1ns/1ns
`default_nettype none
module lcc_cell
  import lcc_pkg::*;
(
  input  wire lcc_pkg::lcc_cfg_s cfg_i,
  input  wire logic [3:0]        data_i,
  input  wire logic              cin_i,
  input  wire logic              chain_i,
  input  wire logic              q_i,
  input  wire logic              step_i,
  input  wire logic              sclr_i,
  input  wire logic              sload_i,
  input  wire logic              aclr_i,
  output logic                   cout_o,
  output logic                   qv_o,
  output logic                   qd_o,
  output logic [2:0]             out_o
);
  import lcc_pkg::*;

  logic       a;
  logic       b;
  logic       lut;
  logic       x;
  logic       nq;
  logic [3:0] idx;

  always_comb begin
    // clear wins at once, without waiting for an edge
    qv_o = aclr_i ? cfg_i.preset : (q_i ^ cfg_i.preset);
    a = data_i[0];
    b = cfg_i.fbk ? qv_o : data_i[1];
    idx = {(cfg_i.carry_sel ? cin_i : data_i[3]), data_i[2], b, a};
    cout_o = (a & b) | (cin_i & (a ^ b));
    lut = cfg_i.arith ? (a ^ b ^ cin_i) : cfg_i.mask[idx];
    x = cfg_i.chain ? chain_i : lut;
    case (cfg_i.ff)
      FF_D:    nq = x;
      FF_T:    nq = qv_o ^ x;
      FF_JK:   nq = (x & ~qv_o) | (~data_i[3] & qv_o);
      FF_SR:   nq = x | (~data_i[3] & qv_o);
      default: nq = x;
    endcase
    if (sclr_i) begin
      nq = 1'b0;
    end else if (sload_i && !cfg_i.pack) begin
      nq = data_i[3];
    end
    // stored value is inverted around the clear to give a preset
    qd_o = aclr_i ? 1'b0 : (step_i ? (nq ^ cfg_i.preset) : q_i);
    for (int j = 0; j < 3; j++) begin
      out_o[j] = cfg_i.out_reg[j] ? qv_o : lut;
    end
  end
endmodule
`default_nettype wire

// ==== lcc_cluster.sv ====
// cluster of sixteen logic cells with shared control and register access
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - each cell has a four-input lookup table for any function of four inputs
// - cell register can act as D, T, JK or SR flip-flop
// - cell register has data, clock, clock enable and clear inputs
// - combinational results bypass the register to the cell outputs
// - three outputs each pick lookup table result or register output
// - with packing, the synchronous load does not touch that cell register
// - feedback mode routes a cell's register into its own lookup table
// - register chain feeds each register from the previous cell's register
// - normal mode picks carry-in or the fourth data input for the table
// - arithmetic mode is a full adder with carry, registered or not
// - carry chain continues into the next cluster down the column
// - a cluster holds sixteen cells with shared control and chains
// - two clocks, two enables, two async clears, sync clear and sync load
// - at most four control signals from local sources, the rest global
// - sync clear acts on all registers at the clock edge, sync load on all but packed ones
// - each cluster clock is tied to its own clock enable
// - a deasserted enable stops its clock, so registers see no edge
// - both clock edges are served by using both cluster clocks
// - two async clears clear their assigned registers at once
// - no async load; preset by inverting around the clear, never both
// - active-low device-wide clear resets all registers and overrides all
// - control signals come from six row clocks or local interconnect
module lcc_cluster
  import lcc_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [7:0]              adr_i,
  input  wire logic [31:0]             dat_i,
  output logic      [31:0]             dat_o,
  input  wire logic                    we_i,
  input  wire logic [3:0]              sel_i,
  input  wire logic                    stb_i,
  input  wire logic                    cyc_i,
  output logic                         ack_o,
  input  wire logic [NCELL-1:0][3:0]   cell_data_i,
  output logic      [NCELL-1:0][2:0]   cell_out_o,
  input  wire logic [5:0]              row_clock_i,
  input  wire logic [NSIG-1:0]         local_ctrl_i,
  input  wire logic                    device_wide_clear_n_i,
  input  wire logic                    carry_in_i,
  output logic                         carry_out_o,
  input  wire logic                    chain_in_i,
  output logic                         chain_out_o
);
  import lcc_pkg::*;

  lcc_state_s       st_q;
  lcc_state_s       st_d;
  logic [NSIG-1:0]  sig;
  logic             over;
  logic             step1;
  logic             step2;
  logic             dev_clr;
  logic [NCELL-1:0] step;
  logic [NCELL-1:0] aclr;
  logic [NCELL-1:0] qv;
  logic [NCELL-1:0] qd;
  logic [NCELL-1:0] cout;
  logic [31:0]      rd;
  logic [31:0]      wmask;

  // control signal sourcing; local picks past the limit read as zero
  always_comb begin
    logic [2:0] s;
    logic [3:0] nloc;
    s = 3'h0;
    nloc = 4'h0;
    over = 1'b0;
    sig = '0;
    for (int i = 0; i < NSIG; i++) begin
      s = st_q.src[i*SRC_W +: SRC_W];
      if (s >= SRC_LOCAL) begin
        nloc = nloc + 4'h1;
        if (nloc <= 4'(MAX_LOCAL)) begin
          sig[i] = local_ctrl_i[i];
        end else begin
          over = 1'b1;
        end
      end else begin
        sig[i] = row_clock_i[s];
      end
    end
  end

  // clock edges seen as sampled levels, each gated by its paired enable
  always_comb begin
    logic e2;
    e2 = st_q.ctrl.two_edge ? (~sig[SIG_CLK1] & st_q.clk_prev[0])
                            : (sig[SIG_CLK2] & ~st_q.clk_prev[1]);
    step1 = sig[SIG_CLK1] & ~st_q.clk_prev[0] & sig[SIG_ENA1];
    step2 = e2 & sig[SIG_ENA2];
    dev_clr = st_q.ctrl.dev_clr_en & ~device_wide_clear_n_i;
  end

  genvar g;
  generate
    for (g = 0; g < NCELL; g++) begin : g_cell
      logic cin_w;
      logic chn_w;
      assign cin_w = (g == 0) ? carry_in_i : cout[(g+NCELL-1)%NCELL];
      assign chn_w = (g == 0) ? chain_in_i : qv[(g+NCELL-1)%NCELL];
      assign step[g] = st_q.cfg[g].clk_sel ? step2 : step1;
      // device clear overrides every other control of the register
      assign aclr[g] = dev_clr | (st_q.cfg[g].clr_en
                     & (st_q.cfg[g].clr_sel ? sig[SIG_ACLR2] : sig[SIG_ACLR1]));
      lcc_cell u_cell (
        .cfg_i   (st_q.cfg[g]),
        .data_i  (cell_data_i[g]),
        .cin_i   (cin_w),
        .chain_i (chn_w),
        .q_i     (st_q.q[g]),
        .step_i  (step[g]),
        .sclr_i  (sig[SIG_SCLR]),
        .sload_i (sig[SIG_SLOAD]),
        .aclr_i  (aclr[g]),
        .cout_o  (cout[g]),
        .qv_o    (qv[g]),
        .qd_o    (qd[g]),
        .out_o   (cell_out_o[g])
      );
    end
  endgenerate

  assign carry_out_o = cout[NCELL-1];
  assign chain_out_o = qv[NCELL-1];
  assign dat_o = st_q.dat;
  assign ack_o = st_q.ack;

  // register read mux; unmapped offsets read zero
  always_comb begin
    rd = 32'h0000_0000;
    if (adr_i < CTRL_OFS) begin
      rd = st_q.cfg[adr_i[5:2]];
    end else if (adr_i == CTRL_OFS) begin
      rd = {30'h0000_0000, st_q.ctrl};
    end else if (adr_i == SRC_OFS) begin
      rd = {8'h00, st_q.src};
    end else if (adr_i == STAT_OFS) begin
      rd = {15'h0000, over, qv};
    end
    for (int k = 0; k < 4; k++) begin
      wmask[k*8 +: 8] = sel_i[k] ? 8'hFF : 8'h00;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.q = qd;
    st_d.clk_prev = {sig[SIG_CLK2], sig[SIG_CLK1]};
    st_d.ack = cyc_i & stb_i & ~st_q.ack;
    if (st_d.ack) begin
      st_d.dat = rd;
    end
    // writes land on the edge that also ends the bus cycle
    if (st_q.ack && cyc_i && stb_i && we_i) begin
      if (adr_i < CTRL_OFS) begin
        st_d.cfg[adr_i[5:2]] = (st_q.cfg[adr_i[5:2]] & ~wmask) | (dat_i & wmask);
      end else if (adr_i == CTRL_OFS) begin
        st_d.ctrl = (st_q.ctrl & ~wmask[1:0]) | (dat_i[1:0] & wmask[1:0]);
      end else if (adr_i == SRC_OFS) begin
        st_d.src = (st_q.src & ~wmask[23:0]) | (dat_i[23:0] & wmask[23:0]);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.cfg <= {NCELL{CFG_RST}};
      st_q.ctrl <= CTRL_RST;
      st_q.src <= SRC_RST;
      st_q.q <= '0;
      st_q.clk_prev <= 2'h0;
      st_q.ack <= 1'b0;
      st_q.dat <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  lut_map_a: assert property (!st_q.cfg[0].arith && !st_q.cfg[0].fbk
    && !st_q.cfg[0].carry_sel && !st_q.cfg[0].out_reg[0]
    |-> cell_out_o[0][0] == st_q.cfg[0].mask[cell_data_i[0]])
    else $error("lookup table output wrong");
  out_sel_a: assert property (st_q.cfg[0].out_reg[1]
    |-> cell_out_o[0][1] == qv[0] && cell_out_o[0][1] == (aclr[0]
    ? st_q.cfg[0].preset : st_q.q[0] ^ st_q.cfg[0].preset))
    else $error("registered output select wrong");
  edge_hold_a: assert property (!st_q.cfg[0].clk_sel && !aclr[0]
    && !sig[SIG_ENA1] |=> $stable(st_q.q[0]))
    else $error("register moved while its enable was low");
  sync_clr_a: assert property (step1 && !st_q.cfg[0].clk_sel
    && sig[SIG_SCLR] && !aclr[0] |=> st_q.q[0] == $past(st_q.cfg[0].preset))
    else $error("sync clear did not clear");
  clr_wins_a: assert property (step1 && sig[SIG_SCLR] && sig[SIG_SLOAD]
    && !aclr[1] && !st_q.cfg[1].clk_sel ##1 !aclr[1] |-> qv[1] == 1'b0)
    else $error("sync load beat sync clear");
  reg_chain_a: assert property (step1 && !st_q.cfg[1].clk_sel
    && st_q.cfg[1].chain && st_q.cfg[1].ff == FF_D && !sig[SIG_SCLR]
    && !sig[SIG_SLOAD] && !aclr[1]
    |=> st_q.q[1] == ($past(qv[0]) ^ $past(st_q.cfg[1].preset)))
    else $error("register chain did not shift");
  dev_clr_a: assert property (st_q.ctrl.dev_clr_en && !device_wide_clear_n_i
    |-> qv == {st_q.cfg[15].preset, st_q.cfg[14].preset, st_q.cfg[13].preset,
    st_q.cfg[12].preset, st_q.cfg[11].preset, st_q.cfg[10].preset,
    st_q.cfg[9].preset, st_q.cfg[8].preset, st_q.cfg[7].preset,
    st_q.cfg[6].preset, st_q.cfg[5].preset, st_q.cfg[4].preset,
    st_q.cfg[3].preset, st_q.cfg[2].preset, st_q.cfg[1].preset,
    st_q.cfg[0].preset} ##1 st_q.q == '0)
    else $error("device clear did not reset all registers");
  async_clr_a: assert property (aclr[2] |-> qv[2] == st_q.cfg[2].preset
    ##1 st_q.q[2] == 1'b0)
    else $error("async clear not immediate");
  adder_a: assert property (st_q.cfg[0].arith && !st_q.cfg[0].fbk
    && !st_q.cfg[0].out_reg[2] |-> cell_out_o[0][2]
    == (cell_data_i[0][0] ^ cell_data_i[0][1] ^ carry_in_i))
    else $error("adder sum wrong");
  t_flop_a: assert property (step1 && !st_q.cfg[0].clk_sel && st_q.cfg[0].ff == FF_T
    && !st_q.cfg[0].chain && !st_q.cfg[0].out_reg[0] && !sig[SIG_SCLR] && !sig[SIG_SLOAD]
    && !aclr[0] |=> st_q.q[0] == ($past(qv[0]) ^ $past(cell_out_o[0][0])
    ^ $past(st_q.cfg[0].preset)))
    else $error("toggle register did not toggle");
  pack_load_a: assert property (step1 && !st_q.cfg[0].clk_sel && st_q.cfg[0].pack
    && st_q.cfg[0].ff == FF_D && !st_q.cfg[0].chain && !st_q.cfg[0].out_reg[0]
    && !sig[SIG_SCLR] && sig[SIG_SLOAD] && !aclr[0]
    |=> st_q.q[0] == ($past(cell_out_o[0][0]) ^ $past(st_q.cfg[0].preset)))
    else $error("sync load reached a packed register");
  fbk_path_a: assert property (!st_q.cfg[0].arith && st_q.cfg[0].fbk
    && !st_q.cfg[0].carry_sel && !st_q.cfg[0].out_reg[0]
    |-> cell_out_o[0][0] == st_q.cfg[0].mask[{cell_data_i[0][3:2], qv[0], cell_data_i[0][0]}])
    else $error("register feedback not in lookup table");
  carry_pick_a: assert property (!st_q.cfg[0].arith && !st_q.cfg[0].fbk
    && st_q.cfg[0].carry_sel && !st_q.cfg[0].out_reg[0]
    |-> cell_out_o[0][0] == st_q.cfg[0].mask[{carry_in_i, cell_data_i[0][2:0]}])
    else $error("carry-in not used as fourth table input");
  rise_quiet_a: assert property (st_q.ctrl.two_edge && st_q.cfg[0].clk_sel
    && sig[SIG_CLK1] && !aclr[0] |=> $stable(st_q.q[0]))
    else $error("second clock stepped on the rising side");
  wb_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not one cycle");

  step_c: cover property (step1 ##[1:4] step2);
  clr_c: cover property (step1 && sig[SIG_SCLR] && sig[SIG_SLOAD]);
  fall_c: cover property (st_q.ctrl.two_edge && step2);
endmodule
`default_nettype wire

// ==== lcc_pkg.sv ====
// shared constants and types for the logic cell cluster
package lcc_pkg;
  localparam int unsigned NCELL      = 16;
  localparam int unsigned NSIG       = 8;
  localparam int unsigned SRC_W      = 3;
  localparam int unsigned MAX_LOCAL  = 4;
  localparam logic [2:0]  SRC_LOCAL  = 3'h6;
  // register offsets (byte addresses)
  localparam logic [7:0]  CFG_OFS    = 8'h00;
  localparam logic [7:0]  CTRL_OFS   = 8'h40;
  localparam logic [7:0]  SRC_OFS    = 8'h44;
  localparam logic [7:0]  STAT_OFS   = 8'h48;
  // control signal slots inside the source register
  localparam int unsigned SIG_CLK1   = 0;
  localparam int unsigned SIG_CLK2   = 1;
  localparam int unsigned SIG_ENA1   = 2;
  localparam int unsigned SIG_ENA2   = 3;
  localparam int unsigned SIG_ACLR1  = 4;
  localparam int unsigned SIG_ACLR2  = 5;
  localparam int unsigned SIG_SCLR   = 6;
  localparam int unsigned SIG_SLOAD  = 7;
  // reset values
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [1:0]  CTRL_RST   = 2'h1;
  localparam logic [23:0] SRC_RST    = 24'hFEC688;

  typedef enum logic [1:0] {
    FF_D  = 2'b00,
    FF_T  = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } lcc_ff_e;

  typedef struct packed {
    logic [1:0]  rsvd;
    logic [2:0]  out_reg;
    logic        pack;
    logic        preset;
    logic        clr_en;
    logic        clr_sel;
    logic        clk_sel;
    logic        chain;
    logic        fbk;
    logic        carry_sel;
    logic        arith;
    lcc_ff_e     ff;
    logic [15:0] mask;
  } lcc_cfg_s;

  typedef struct packed {
    logic two_edge;
    logic dev_clr_en;
  } lcc_ctrl_s;

  typedef struct packed {
    lcc_cfg_s [NCELL-1:0] cfg;
    lcc_ctrl_s            ctrl;
    logic [23:0]          src;
    logic [NCELL-1:0]     q;
    logic [1:0]           clk_prev;
    logic                 ack;
    logic [31:0]          dat;
  } lcc_state_s;
endpackage

// ==== tb_top.sv ====
// self-checking bench for the logic cell cluster
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lcc_pkg::*;
  logic                  clk, rst, we, stb, cyc, ack, dcn, cin, cout, chin, chout;
  logic [7:0]            adr;
  logic [31:0]           wdat, rdat, rd;
  logic [3:0]            sel;
  logic [NCELL-1:0][3:0] cdat;
  logic [NCELL-1:0][2:0] cout3;
  logic [5:0]            row;
  logic [NSIG-1:0]       lctl;
  int                    mismatches, n_checks;

  lcc_cluster u_lcc_cluster (.clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .dat_o(rdat),
    .we_i(we), .sel_i(sel), .stb_i(stb), .cyc_i(cyc), .ack_o(ack), .cell_data_i(cdat),
    .cell_out_o(cout3), .row_clock_i(row), .local_ctrl_i(lctl), .device_wide_clear_n_i(dcn),
    .carry_in_i(cin), .carry_out_o(cout), .chain_in_i(chin), .chain_out_o(chout));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // one pulse on a sampled row clock, rise then fall; long enough for each sampled step to land
  task automatic step(input int r);
    @(posedge clk);
    row[r] <= 1'b1;
    repeat (3) @(posedge clk);
    row[r] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // looks at the settled outputs mid-cycle, hands back on a rising edge for the next drive
  task automatic outchk(input int c, input int o, input logic exp);
    @(negedge clk);
    chk("cell output", {31'h0, exp}, {31'h0, cout3[c][o]});
    @(posedge clk);
  endtask

  task automatic pinchk(input int p, input logic exp);
    @(negedge clk);
    if (p == 0)
      chk("carry out", {31'h0, exp}, {31'h0, cout});
    else
      chk("chain out", {31'h0, exp}, {31'h0, chout});
    @(posedge clk);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    rst = 1'b1; we = 1'b0; stb = 1'b0; cyc = 1'b0; adr = 8'h00; wdat = 32'h0; sel = 4'hF;
    cdat = '0; row = 6'h04; lctl = 8'h00; dcn = 1'b1; cin = 1'b0; chin = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", {30'h0, CTRL_RST}, rd);
    wb(1'b0, SRC_OFS, 32'h0);
    chk("src", {8'h00, SRC_RST}, rd);
    wb(1'b0, CFG_OFS + 8'h3C, 32'h0);
    chk("cfg15", CFG_RST, rd);
    wb(1'b1, 8'h4C, 32'hFFFFFFFF);
    wb(1'b0, 8'h4C, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, SRC_OFS, 32'h00FFFFFF);
    wb(1'b0, STAT_OFS, 32'h0);
    chk("status local", 32'h00010000, rd);
    wb(1'b1, SRC_OFS, {8'h00, SRC_RST});
    // cell 0: parity of four inputs, output one shows the register
    wb(1'b1, CFG_OFS, 32'h10006996);
    for (int i = 0; i < 16; i++) begin
      cdat[0] <= 4'(i);
      outchk(0, 0, ^(4'(i)));
    end
    cdat[0] <= 4'h1;
    step(0);
    outchk(0, 1, 1'b1);
    cdat[0] <= 4'h3;
    outchk(0, 0, 1'b0);
    outchk(0, 1, 1'b1);
    row[2] <= 1'b0;
    step(0);
    outchk(0, 1, 1'b1);
    row[2] <= 1'b1;
    step(0);
    outchk(0, 1, 1'b0);
    cdat[0] <= 4'h1;
    step(0);
    lctl <= 8'hC0;
    cdat[0] <= 4'h9;
    step(0);
    outchk(0, 1, 1'b0);
    lctl <= 8'h80;
    cdat[0] <= 4'h9;
    step(0);
    outchk(0, 1, 1'b1);
    wb(1'b1, CFG_OFS, 32'h14006996);
    step(0);
    outchk(0, 1, 1'b0);
    lctl <= 8'h00;
    wb(1'b1, CFG_OFS, 32'h11006996);
    cdat[0] <= 4'h1;
    step(0);
    row[4] <= 1'b1;
    outchk(0, 1, 1'b0);
    wb(1'b1, CFG_OFS, 32'h13006996);
    outchk(0, 1, 1'b1);
    row[4] <= 1'b0;
    cdat[0] <= 4'h3;
    step(0);
    outchk(0, 1, 1'b0);
    wb(1'b1, CFG_OFS, 32'h10006996);
    cdat[0] <= 4'h1;
    step(0);
    dcn <= 1'b0;
    outchk(0, 1, 1'b0);
    dcn <= 1'b1;
    // cell 1 takes its register from cell 0
    wb(1'b1, CFG_OFS + 8'h04, 32'h38200000);
    step(0);
    step(0);
    cdat[0] <= 4'h3;
    step(0);
    outchk(0, 1, 1'b0);
    outchk(1, 0, 1'b1);
    // table inverts input b, which feedback takes from the cell's own register
    wb(1'b1, CFG_OFS, 32'h10103333);
    cdat[0] <= 4'h0;
    step(0);
    outchk(0, 1, 1'b1);
    step(0);
    outchk(0, 1, 1'b0);
    wb(1'b1, CFG_OFS, 32'h1001AAAA);
    cdat[0] <= 4'h1;
    step(0);
    outchk(0, 1, 1'b1);
    step(0);
    outchk(0, 1, 1'b0);
    wb(1'b1, CFG_OFS, 32'h1002AAAA);
    cdat[0] <= 4'h9;
    step(0);
    outchk(0, 1, 1'b1);
    step(0);
    outchk(0, 1, 1'b0);
    wb(1'b1, CFG_OFS, 32'h1003AAAA);
    cdat[0] <= 4'h1;
    step(0);
    outchk(0, 1, 1'b1);
    cdat[0] <= 4'h0;
    step(0);
    outchk(0, 1, 1'b1);
    // clock two follows the falling side of clock one
    wb(1'b1, CTRL_OFS, 32'h3);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h3, rd);
    wb(1'b1, CFG_OFS, 32'h1040AAAA);
    row[3] <= 1'b1;
    step(0);
    outchk(0, 1, 1'b0);
    row[3] <= 1'b0;
    cdat[0] <= 4'h1;
    step(0);
    outchk(0, 1, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b1, CFG_OFS, 32'h10200000);
    step(0);
    outchk(0, 1, 1'b0);
    chin <= 1'b1;
    step(0);
    outchk(0, 1, 1'b1);
    chin <= 1'b0;
    pinchk(1, 1'b0);
    wb(1'b1, CFG_OFS + 8'h3C, 32'h02000000);
    pinchk(1, 1'b1);
    wb(1'b1, CFG_OFS, 32'h10086996);
    cdat[0] <= 4'h0;
    cin <= 1'b1;
    outchk(0, 0, 1'b1);
    // all cells add: a=1, b=0 lets the carry ripple through the whole cluster
    for (int i = 0; i < 16; i++) wb(1'b1, CFG_OFS + 8'(4 * i), 32'h00040000);
    cdat <= {NCELL{4'h1}};
    pinchk(0, 1'b1);
    outchk(1, 0, 1'b0);
    cin <= 1'b0;
    pinchk(0, 1'b0);
    outchk(1, 0, 1'b1);
    cdat <= {NCELL{4'h3}};
    pinchk(0, 1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
